/* File: sram_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Memory controller: makes the input clock and drives one bus cycle per call of cyc.
module sram_ctl_model (
	// Input clock.
	output logic                              k_clk,
	// Selects, address and write data.
	output logic                              rd_sel_n,
	output logic                              wr_sel_n,
	output logic [sram_link_pkg::ADDR_W-1:0]  addr,
	output logic [sram_link_pkg::WORD_W-1:0]  d,
	output logic [sram_link_pkg::LANES-1:0]   mask_n
);
	// A 30 ns clock, far below the legacy ceiling; it runs free so the loop can lock.
	initial
	begin
		k_clk = 1'b0;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		addr = '0;
		d = '0;
		mask_n = 2'h3;
		forever #15 k_clk = ~k_clk;
	end

	// First half sets selects, read address and word0; second half write address and word1.
	task automatic cyc(input logic rd, input logic wr, input logic [21:0] ra, input logic [21:0] wa,
		input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m);
		@(negedge k_clk);
		#1;
		rd_sel_n = !rd;
		wr_sel_n = !wr;
		addr = rd ? ra : ~addr;
		d = wr ? d0 : ~d;
		mask_n = m;
		@(posedge k_clk);
		#1;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		addr = wr ? wa : ~addr;
		d = wr ? d1 : ~d;
	endtask
endmodule

`default_nettype wire

/* File: sram_link.sv */

`timescale 1ns/100ps
`default_nettype none

// Synchronous queue with valid and ready on both sides.
module burst_write_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PW-1:0]    wr_ptr_reg, rd_ptr_reg;
	logic [PW:0]      count_reg;
	logic             push, pop;

	// Honest full and empty come from the occupancy count.
	assign in_ready  = (count_reg != DEPTH[PW:0]);
	assign out_valid = (count_reg != '0);
	assign out_data  = store[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage is written on push only and never reset.
	always_ff @(posedge clk)
	begin
		if (push)
			store[wr_ptr_reg] <= in_data;
	end

	// Pointers wrap at the depth, which is a power of two.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			count_reg  <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end

endmodule

// Memory device behind its pins: link logic on the input clock, loop lock tracking on MCLK.
module sram_link (
	// System clock and reset.
	input  wire logic                                  MCLK,
	input  wire logic                                  RST_N,
	// Input clock; its falling edge stands for the rise of the negative input clock.
	input  wire logic                                  K_CLK,
	// Static strap.
	input  wire logic                                  PLL_DISABLE_N,
	// Shared address and port selects.
	input  wire logic [sram_link_pkg::ADDR_W-1:0]      ADDR,
	input  wire logic                                  READ_PORT_SELECT_N,
	input  wire logic                                  WRITE_PORT_SELECT_N,
	// Write port.
	input  wire logic [sram_link_pkg::WORD_W-1:0]      D,
	input  wire logic [sram_link_pkg::LANES-1:0]       LANE_WRITE_MASK_N,
	output logic                                       WRITE_READY,
	// Read port.
	output logic      [sram_link_pkg::WORD_W-1:0]      Q,
	output logic                                       Q_OE,
	// Loop status.
	output logic                                       LOCKED
);

	localparam int AW = sram_link_pkg::ADDR_W;
	localparam int WW = sram_link_pkg::WORD_W;
	localparam int NL = sram_link_pkg::LANES;
	localparam int EW = sram_link_pkg::ENTRY_W;
	localparam int RW = $clog2(sram_link_pkg::FIFO_DEPTH) + 1;

	// Merges new lanes into an old word where the active-low mask allows.
	function automatic logic [WW-1:0] lane_merge(input logic [WW-1:0] old_w,
		input logic [WW-1:0] new_w, input logic [NL-1:0] mask_n);
		logic [WW-1:0] res;
		res = old_w;
		for (int i = 0; i < NL; i++)
			if (!mask_n[i])
				res[i*sram_link_pkg::LANE_W +: sram_link_pkg::LANE_W] =
					new_w[i*sram_link_pkg::LANE_W +: sram_link_pkg::LANE_W];
		return res;
	endfunction

	// Array: low word and high word of each burst location.
	logic [WW-1:0] mem_lo [0:(1<<AW)-1];
	logic [WW-1:0] mem_hi [0:(1<<AW)-1];

	// ---- MCLK domain: input clock activity and loop lock timing ----
	logic                                  k_toggle_reg, k_tog_s1_reg, k_tog_s2_reg, k_tog_s3_reg;
	logic                                  k_seen, k_stopped;
	logic [sram_link_pkg::IDLE_CNT_W-1:0]  idle_reg, idle_next;
	logic [sram_link_pkg::LOCK_CNT_W-1:0]  lock_cnt_reg, lock_cnt_next;
	sram_link_pkg::lock_state_t            lock_state_reg, lock_state_next;

	// Activity detection looks at the second and third stages, never at the first.
	assign k_seen    = k_tog_s2_reg ^ k_tog_s3_reg;
	assign idle_next = k_seen ? '0 : (k_stopped ? idle_reg : idle_reg + 1'b1);
	assign k_stopped = (idle_reg > sram_link_pkg::IDLE_CNT_W'(sram_link_pkg::STOP_CYC));

	// The toggle of the input clock is carried over by three flip-flops.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			k_tog_s1_reg <= 1'b0;
			k_tog_s2_reg <= 1'b0;
			k_tog_s3_reg <= 1'b0;
			idle_reg     <= '0;
		end
		else
		begin
			k_tog_s1_reg <= k_toggle_reg;
			k_tog_s2_reg <= k_tog_s1_reg;
			k_tog_s3_reg <= k_tog_s2_reg;
			idle_reg     <= idle_next;
		end
	end

	// Lock after a stretch of stable clock; a stopped clock starts the wait over.
	always_comb
	begin
		lock_state_next = lock_state_reg;
		lock_cnt_next   = lock_cnt_reg;
		case (lock_state_reg)
			sram_link_pkg::LK_IDLE:
			begin
				lock_cnt_next = '0;
				if (k_seen)
					lock_state_next = sram_link_pkg::LK_COUNT;
			end
			sram_link_pkg::LK_COUNT:
			begin
				lock_cnt_next = lock_cnt_reg + 1'b1;
				if (k_stopped)
					lock_state_next = sram_link_pkg::LK_IDLE;
				else if (lock_cnt_reg == sram_link_pkg::LOCK_CNT_W'(sram_link_pkg::LOCK_CYC - 1))
					lock_state_next = sram_link_pkg::LK_LOCKED;
			end
			sram_link_pkg::LK_LOCKED:
			begin
				if (k_stopped)
					lock_state_next = sram_link_pkg::LK_IDLE;
			end
			default:
				lock_state_next = sram_link_pkg::LK_IDLE;
		endcase
	end

	// Lock state registers; the status pin is the locked state.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			lock_state_reg <= sram_link_pkg::LK_IDLE;
			lock_cnt_reg   <= '0;
			LOCKED         <= 1'b0;
		end
		else
		begin
			lock_state_reg <= lock_state_next;
			lock_cnt_reg   <= lock_cnt_next;
			LOCKED         <= (lock_state_next == sram_link_pkg::LK_LOCKED);
		end
	end

	// ---- Input clock domain: pin capture, array access and output launch ----
	logic          lock_s1_reg, lock_s2_reg, strap_s1_reg, legacy_reg, rd_pend_reg, hold_v_reg, oe_pos_reg, oe_neg_reg;
	logic          out_allowed, rd_start, wr_pend_reg, wv_reg, wq_valid, wq_drain, wr_take;
	logic [AW-1:0] rd_addr_reg, wa_reg, cm_addr;
	logic [WW-1:0] hold_lo_reg, hold_hi_reg, q_pos_reg, q_neg_reg, rd_lo, rd_hi, wd0_reg, wd1_reg;
	logic [NL-1:0] wm0_reg, wm1_reg;
	logic [EW-1:0] wq_in, wq_out;
	logic [RW-1:0] resv_reg;

	// Lock status and strap each pass two flip-flops before use.
	always_ff @(posedge K_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			k_toggle_reg <= 1'b0;
			lock_s1_reg  <= 1'b0;
			lock_s2_reg  <= 1'b0;
			strap_s1_reg <= 1'b1;
			legacy_reg   <= 1'b0;
		end
		else
		begin
			k_toggle_reg <= ~k_toggle_reg;
			lock_s1_reg  <= LOCKED;
			lock_s2_reg  <= lock_s1_reg;
			strap_s1_reg <= PLL_DISABLE_N;
			legacy_reg   <= ~strap_s1_reg;
		end
	end

	// Loop mode only drives data once the loop has locked.
	assign out_allowed = legacy_reg | lock_s2_reg;
	assign rd_start    = ~READ_PORT_SELECT_N & out_allowed;
	assign rd_lo       = mem_lo[rd_addr_reg];
	assign rd_hi       = mem_hi[rd_addr_reg];

	// Read select and its address are taken at the positive rise; the hold stage keeps the burst for one more cycle.
	always_ff @(posedge K_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
			hold_lo_reg <= sram_link_pkg::Q_RESET;
			hold_hi_reg <= sram_link_pkg::Q_RESET;
			hold_v_reg  <= 1'b0;
		end
		else
		begin
			rd_pend_reg <= rd_start;
			if (rd_start)
				rd_addr_reg <= ADDR;
			hold_lo_reg <= rd_lo;
			hold_hi_reg <= rd_hi;
			hold_v_reg  <= rd_pend_reg;
		end
	end

	// Positive-rise output register: legacy word one, or loop-mode word two at t+2.
	always_ff @(posedge K_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			q_pos_reg  <= sram_link_pkg::Q_RESET;
			oe_pos_reg <= 1'b0;
		end
		else
		begin
			q_pos_reg  <= legacy_reg ? rd_lo : hold_hi_reg;
			oe_pos_reg <= legacy_reg ? rd_pend_reg : hold_v_reg;
		end
	end

	// Negative-rise output register: legacy word two, or loop-mode word one at t+1.5.
	always_ff @(negedge K_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			q_neg_reg  <= sram_link_pkg::Q_RESET;
			oe_neg_reg <= 1'b0;
		end
		else
		begin
			q_neg_reg  <= legacy_reg ? hold_hi_reg : hold_lo_reg;
			oe_neg_reg <= hold_v_reg;
		end
	end

	// Double-rate output: each half period shows the register of its own edge.
	assign Q    = K_CLK ? q_pos_reg : q_neg_reg;
	assign Q_OE = K_CLK ? oe_pos_reg : oe_neg_reg;

	// First write word and its mask are captured at the positive rise, and a queue slot is reserved.
	always_ff @(posedge K_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wr_pend_reg <= 1'b0;
			wd0_reg     <= '0;
			wm0_reg     <= '1;
			resv_reg    <= '0;
		end
		else
		begin
			wr_pend_reg <= wr_take;
			resv_reg    <= resv_reg + RW'(wr_take) - RW'(wq_valid & wq_drain);
			wd0_reg     <= D;
			wm0_reg     <= LANE_WRITE_MASK_N;
		end
	end

	// Second word, its mask and the write address are captured at the negative rise.
	always_ff @(negedge K_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wv_reg  <= 1'b0;
			wa_reg  <= '0;
			wd1_reg <= '0;
			wm1_reg <= '1;
		end
		else
		begin
			wv_reg  <= wr_pend_reg;
			wa_reg  <= ADDR;
			wd1_reg <= D;
			wm1_reg <= LANE_WRITE_MASK_N;
		end
	end

	// One negative rise falls between two positive rises, so each write pushes once.
	assign wq_in = {wa_reg, wm1_reg, wd1_reg, wm0_reg, wd0_reg};

	burst_write_fifo #(.WIDTH (EW), .DEPTH (sram_link_pkg::FIFO_DEPTH)) write_queue (
		.clk       (K_CLK),
		.rst_n     (RST_N),
		.in_valid  (wv_reg),
		.in_ready  (),
		.in_data   (wq_in),
		.out_valid (wq_valid),
		.out_ready (wq_drain),
		.out_data  (wq_out)
	);

	// A read starting at this edge gets the array; room counts taken writes still in flight to the queue.
	assign wq_drain    = ~rd_start;
	assign wr_take     = ~WRITE_PORT_SELECT_N & WRITE_READY;
	assign WRITE_READY = (resv_reg != RW'(sram_link_pkg::FIFO_DEPTH));
	assign cm_addr  = wq_out[sram_link_pkg::ENT_A_LSB +: AW];

	// Commit one queued burst, leaving masked lanes unchanged.
	always_ff @(posedge K_CLK)
	begin
		if (wq_valid & wq_drain)
		begin
			mem_lo[cm_addr] <= lane_merge(mem_lo[cm_addr], wq_out[sram_link_pkg::ENT_D0_LSB +: WW],
				wq_out[sram_link_pkg::ENT_M0_LSB +: NL]);
			mem_hi[cm_addr] <= lane_merge(mem_hi[cm_addr], wq_out[sram_link_pkg::ENT_D1_LSB +: WW],
				wq_out[sram_link_pkg::ENT_M1_LSB +: NL]);
		end
	end

endmodule

`default_nettype wire

/* File: sram_link_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

// Watches the pins for read burst timing, output float, queue and lock behaviour.
module sram_link_asserts (
	// Clocks and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic K_CLK,
	// Observed pins.
	input wire logic PLL_DISABLE_N,
	input wire logic READ_PORT_SELECT_N,
	input wire logic WRITE_PORT_SELECT_N,
	input wire logic WRITE_READY,
	input wire logic Q_OE,
	input wire logic LOCKED
);
	logic [2:0] rd_reg;
	logic [2:0] lg_reg;
	logic [9:0] mcnt_reg;

	// Pipes of taken reads and their mode, one stage per input clock rise.
	always_ff @(posedge K_CLK or negedge RST_N)
		if (!RST_N)
		begin
			rd_reg <= 3'h0;
			lg_reg <= 3'h0;
		end
		else
		begin
			rd_reg <= {rd_reg[1:0], !READ_PORT_SELECT_N && (!PLL_DISABLE_N || LOCKED)};
			lg_reg <= {lg_reg[1:0], !PLL_DISABLE_N};
		end

	// System clock cycles since reset, saturating.
	always_ff @(posedge MCLK or negedge RST_N)
		if (!RST_N)
			mcnt_reg <= 10'h000;
		else if (mcnt_reg != 10'h3ff)
			mcnt_reg <= mcnt_reg + 10'h001;

	property p_leg_w0;
		@(negedge K_CLK) disable iff (!RST_N) rd_reg[1] && lg_reg[1] |-> Q_OE;
	endproperty
	a_leg_w0: assert property (p_leg_w0) else $error("legacy first word not driven");
	property p_leg_w1;
		@(posedge K_CLK) disable iff (!RST_N) rd_reg[1] && lg_reg[1] |-> Q_OE;
	endproperty
	a_leg_w1: assert property (p_leg_w1) else $error("legacy second word not driven");
	property p_loop_w0;
		@(posedge K_CLK) disable iff (!RST_N) rd_reg[1] && !lg_reg[1] |-> Q_OE;
	endproperty
	a_loop_w0: assert property (p_loop_w0) else $error("loop first word not driven");
	property p_loop_w1;
		@(negedge K_CLK) disable iff (!RST_N) rd_reg[2] && !lg_reg[2] |-> Q_OE;
	endproperty
	a_loop_w1: assert property (p_loop_w1) else $error("loop second word not driven");
	property p_float_lo;
		@(posedge K_CLK) disable iff (!RST_N) rd_reg == 3'h0 |-> !Q_OE;
	endproperty
	a_float_lo: assert property (p_float_lo) else $error("output driven without read");
	property p_float_hi;
		@(negedge K_CLK) disable iff (!RST_N) rd_reg == 3'h0 |-> !Q_OE;
	endproperty
	a_float_hi: assert property (p_float_hi) else $error("output driven without read");
	property p_full_cause;
		@(posedge K_CLK) disable iff (!RST_N) $fell(WRITE_READY) |-> $past(WRITE_PORT_SELECT_N, 1) == 1'b0;
	endproperty
	a_full_cause: assert property (p_full_cause) else $error("queue filled without write");
	property p_lock_wait;
		@(posedge MCLK) disable iff (!RST_N) mcnt_reg < 10'h316 |-> !LOCKED;
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("lock reported too early");
endmodule

bind sram_link sram_link_asserts i_sram_link_asserts (
	.MCLK(MCLK), .RST_N(RST_N), .K_CLK(K_CLK), .PLL_DISABLE_N(PLL_DISABLE_N),
	.READ_PORT_SELECT_N(READ_PORT_SELECT_N), .WRITE_PORT_SELECT_N(WRITE_PORT_SELECT_N),
	.WRITE_READY(WRITE_READY), .Q_OE(Q_OE), .LOCKED(LOCKED));

`default_nettype wire

/* File: sram_link_bench.sv */
`timescale 1ns/100ps
`default_nettype none

// Drives the memory through the controller model and checks read data and timing.
module sram_link_bench;
	logic        MCLK;
	logic        RST_N;
	logic        PLL_DISABLE_N;
	logic        K_CLK;
	logic        rd_n;
	logic        wr_n;
	logic [21:0] addr;
	logic [17:0] d;
	logic [1:0]  mask_n;
	logic        WRITE_READY;
	logic [17:0] Q;
	logic        Q_OE;
	logic        LOCKED;
	int          error_cnt = 0;
	int          checks = 0;

	sram_ctl_model i_sram_ctl_model (.k_clk(K_CLK), .rd_sel_n(rd_n), .wr_sel_n(wr_n),
		.addr(addr), .d(d), .mask_n(mask_n));
	sram_link i_sram_link (.MCLK(MCLK), .RST_N(RST_N), .K_CLK(K_CLK), .PLL_DISABLE_N(PLL_DISABLE_N),
		.ADDR(addr), .READ_PORT_SELECT_N(rd_n), .WRITE_PORT_SELECT_N(wr_n), .D(d),
		.LANE_WRITE_MASK_N(mask_n), .WRITE_READY(WRITE_READY), .Q(Q), .Q_OE(Q_OE), .LOCKED(LOCKED));

	// System clock of 25 ns.
	initial
	begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end

	// Compares one value and counts.
	task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic rst();
		RST_N = 1'b0;
		repeat (4) @(posedge MCLK);
		#1 RST_N = 1'b1;
		repeat (4) @(posedge K_CLK);
	endtask

	task automatic idle(input int n);
		repeat (n) i_sram_ctl_model.cyc(1'b0, 1'b0, 22'h0, 22'h0, 18'h0, 18'h0, 2'h3);
	endtask

	task automatic wr(input logic [21:0] a, input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m);
		i_sram_ctl_model.cyc(1'b0, 1'b1, 22'h0, a, d0, d1, m);
		idle(2);
	endtask

	// Reads one burst and checks both words in the phases that the mode gives.
	task automatic rd_chk(input logic [21:0] a, input logic [17:0] lo, input logic [17:0] hi);
		i_sram_ctl_model.cyc(1'b1, 1'b0, a, 22'h0, 18'h0, 18'h0, 2'h3);
		@(posedge K_CLK);
		if (PLL_DISABLE_N)
			@(negedge K_CLK);
		#1 chk("q word0", Q, lo);
		chk("oe word0", 18'(Q_OE), 18'h1);
		if (PLL_DISABLE_N)
			@(posedge K_CLK);
		else
			@(negedge K_CLK);
		#1 chk("q word1", Q, hi);
		chk("oe word1", 18'(Q_OE), 18'h1);
		@(negedge K_CLK);
		#1 chk("oe float", 18'(Q_OE), 18'h0);
	endtask

	task automatic t_legacy();
		wr(22'h0000a5, 18'h1a2b3, 18'h0c4d5, 2'h0);
		rd_chk(22'h0000a5, 18'h1a2b3, 18'h0c4d5);
		$display("test legacy done");
	endtask

	task automatic t_lock();
		PLL_DISABLE_N = 1'b1;
		rst();
		for (int i = 0; i < 1000 && LOCKED !== 1'b1; i++)
			@(posedge MCLK);
		chk("locked", 18'(LOCKED), 18'h1);
		idle(8);
		$display("test lock done");
	endtask

	// Second write masks lane 0, so only the upper nine bits change.
	task automatic t_mask();
		wr(22'h3f0001, 18'h15555, 18'h0aaaa, 2'h0);
		wr(22'h3f0001, 18'h3ffff, 18'h3ffff, 2'h1);
		rd_chk(22'h3f0001, {9'h1ff, 9'h155}, {9'h1ff, 9'h0aa});
		$display("test mask done");
	endtask

	// Reads every cycle block commits, so back-to-back writes fill the queue.
	task automatic t_fill();
		logic full;
		int   took;
		full = 1'b0;
		took = 0;
		for (int i = 0; i < 12; i++)
		begin
			if (WRITE_READY === 1'b0)
				full = 1'b1;
			else
				took++;
			i_sram_ctl_model.cyc(1'b1, 1'b1, 22'h3f0001, 22'h100 + 22'(i), 18'h100 + 18'(i),
				18'h200 + 18'(i), 2'h0);
		end
		chk("queue full", 18'(full), 18'h1);
		chk("writes taken", 18'(took), 18'(sram_link_pkg::FIFO_DEPTH));
		idle(12);
		chk("queue drained", 18'(WRITE_READY), 18'h1);
		rd_chk(22'h000100, 18'h00100, 18'h00200);
		rd_chk(22'h100 + 22'(took - 1), 18'h100 + 18'(took - 1), 18'h200 + 18'(took - 1));
		$display("test fill done");
	endtask

	// Cuts a hang short well after the lock wait and all tests.
	initial
	begin
		#400000;
		error_cnt++;
		wrap_up();
	end

	initial
	begin
		PLL_DISABLE_N = 1'b0;
		RST_N = 1'b0;
		rst();
		t_legacy();
		t_lock();
		t_mask();
		t_fill();
		wrap_up();
	end
endmodule

`default_nettype wire

/* File: sram_link_pkg.sv */
// Shared constants for the split-port double-data-rate burst memory.
package sram_link_pkg;

	// Data organisation: two lanes of nine bits make one word, two words one burst.
	localparam int WORD_W      = 18;
	localparam int LANE_W      = 9;
	localparam int LANES       = 2;
	localparam int ADDR_W      = 22;

	// Write queue between the pin capture and the array.
	localparam int FIFO_DEPTH  = 8;

	// Field positions inside one queued write entry {addr, mask1, word1, mask0, word0}.
	localparam int ENT_D0_LSB  = 0;
	localparam int ENT_M0_LSB  = ENT_D0_LSB + WORD_W;
	localparam int ENT_D1_LSB  = ENT_M0_LSB + LANES;
	localparam int ENT_M1_LSB  = ENT_D1_LSB + WORD_W;
	localparam int ENT_A_LSB   = ENT_M1_LSB + LANES;
	localparam int ENTRY_W     = ENT_A_LSB + ADDR_W;

	// Timing on the 40 MHz system clock.
	localparam int MCLK_PERIOD_NS = 25;
	localparam int LOCK_TIME_NS   = 20000;
	localparam int STOP_TIME_NS   = 30;
	localparam int LOCK_CYC       = (LOCK_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int STOP_CYC       = (STOP_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int LOCK_CNT_W     = 10;
	localparam int IDLE_CNT_W     = 3;

	// Reset values.
	localparam logic [WORD_W-1:0] Q_RESET = 18'h00000;

	// States of the loop lock tracker.
	typedef enum logic [2:0]
	{
		LK_IDLE   = 3'b001,
		LK_COUNT  = 3'b010,
		LK_LOCKED = 3'b100
	} lock_state_t;

endpackage
